//--- fault_status_pkg.sv
// Constants, types and fault class table for the fault and status manager
package fault_status_pkg;

  localparam int CODE_W = 7;
  localparam int MEAS_W = 16;
  localparam int TIME_W = 32;
  localparam int AIN_W = 12;
  localparam int LOG_DEPTH = 10;
  localparam int PTR_W = 4;
  localparam int NUM_CODES = 100;
  localparam int ENTRY_W = TIME_W + CODE_W + MEAS_W;

  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;
  localparam int SLOW_HALF_MS = 500;
  localparam int FAST_HALF_MS = 125;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int SLOW_HALF_CYCLES_DEF = CLK_HZ / 1000 * SLOW_HALF_MS;
  localparam int FAST_HALF_CYCLES_DEF = CLK_HZ / 1000 * FAST_HALF_MS;

  // Fault class bits: which severities a code may raise
  localparam int CLS_WARN = 0;
  localparam int CLS_ALARM = 1;
  localparam int CLS_LOCK = 2;
  localparam logic [2:0] CLS_NONE = 3'h0;
  localparam logic [2:0] CLS_W = 3'h1;
  localparam logic [2:0] CLS_A = 3'h2;
  localparam logic [2:0] CLS_WA = 3'h3;
  localparam logic [2:0] CLS_AL = 3'h6;
  localparam logic [2:0] CLS_WAL = 3'h7;

  // Codes handled specially
  localparam logic [CODE_W-1:0] FC_LIVE_ZERO = 7'h02;
  localparam logic [CODE_W-1:0] FC_MOTOR_OVL = 7'h0a;
  localparam logic [CODE_W-1:0] FC_THERMISTOR = 7'h0b;

  // Reset values
  localparam logic [TIME_W-1:0] TIME_RST = 32'h0000_0000;
  localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
  localparam logic [MEAS_W-1:0] MEAS_RST = 16'h0000;

  typedef enum logic [1:0] {SEV_WARN, SEV_ALARM, SEV_LOCK} sev_e;
  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_SLOW, ST_FAST} stat_mode_e;
  typedef enum logic [1:0] {TS_RUN, TS_TRIP, TS_LOCK} trip_state_e;

  function automatic logic [2:0] fault_class(input logic [CODE_W-1:0] c);
    logic [2:0] r;
    r = CLS_NONE;
    case (c)
      7'h02, 7'h04, 7'h07, 7'h08, 7'h0d: r = CLS_WAL;
      7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h11, 7'h12, 7'h22, 7'h24: r = CLS_WA;
      7'h0e, 7'h0f, 7'h10, 7'h23: r = CLS_AL;
      7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h2d:
        r = CLS_AL;
      7'h05, 7'h06, 7'h21, 7'h63: r = CLS_W;
      7'h32, 7'h33, 7'h36, 7'h37, 7'h38: r = CLS_A;
      default: r = CLS_NONE;
    endcase
    return r;
  endfunction

endpackage

//--- flash_gen.sv
// Square wave generator for LED flashing
`timescale 1ns/1ns
`default_nettype none
module flash_gen #(
  parameter int unsigned HALF_CYCLES = 25_000_000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic phase_o
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (cnt_r == CW'(HALF_CYCLES - 1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // Starts lit so a fresh indication shows at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_o <= 1'b1;
    end else if (cnt_r == CW'(HALF_CYCLES - 1)) begin
      phase_o <= ~phase_o;
    end
  end
endmodule
`default_nettype wire

//--- fault_log_mem.sv
// Fault log storage with registered read data
`timescale 1ns/1ns
`default_nettype none
module fault_log_mem
  import fault_status_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [PTR_W-1:0] waddr_i,
  input wire logic [ENTRY_W-1:0] wdata_i,
  input wire logic [PTR_W-1:0] raddr_i,
  output logic [ENTRY_W-1:0] rdata_o
);
  logic [ENTRY_W-1:0] mem_r [LOG_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule
`default_nettype wire

//--- fault_status_manager.sv
// Fault classification, trip handling, LED drive and fault log
//
// Summary of operation
// - Five LEDs show status, bus, alarm, warning and power-on.
// - Log keeps ten most recent alarms and trip locks, each readable by index.
// - Each entry holds the internal clock time of the fault.
// - Each entry holds the fault code.
// - Each entry holds a measurement taken just before the fault.
// - Status LED off while healthy, else follows its configured mode.
// - Bus LED on OK, slow local, fast no master, off not OK.
// - Alarm LED flashes while trip or trip lock exists.
// - Warning LED flashes while a warning exists.
// - Power LED lit when mains or auxiliary supply present.
// - Warnings clear themselves; alarms stay latched until reset.
// - Trip lock flashes both LEDs; clears only after mains cycle and reset.
// - Trip cleared by panel key, digital input or serial command.
// - Optional automatic trip reset when enabled.
// - Thermal protection setting chooses warning or alarm for its faults.
// - Trip coasts motor; cause gone leaves only alarm; reset readies.
// - Codes 2,4,7,8,13 may warn, alarm or trip-lock.
// - Codes 9-12,17,18,34,36 may warn or alarm, never lock.
// - Codes 14-16,35,37-45 always raise a locked alarm.
// - Codes 5,6,33,99 only warn.
// - Motor tuning codes 50,51,54-56 only alarm.
// - Live zero fault when analog input below half its minimum.
`timescale 1ns/1ns
`default_nettype none
module fault_status_manager
  import fault_status_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned SLOW_HALF_CYCLES = SLOW_HALF_CYCLES_DEF,
  parameter int unsigned FAST_HALF_CYCLES = FAST_HALF_CYCLES_DEF
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Fault event source
  input wire logic FAULT_VALID_I,
  input wire logic [CODE_W-1:0] FAULT_CODE_I,
  input wire logic FAULT_ACTIVE_I,
  input wire logic [1:0] FAULT_SEV_I,
  input wire logic [MEAS_W-1:0] MEAS_I,
  // Configuration
  input wire logic MOTOR_THERM_ALARM_I,
  input wire logic AUTO_RESET_EN_I,
  input wire logic [1:0] STATUS_LED_MODE_I,
  input wire logic LIVE_ZERO_EN_I,
  input wire logic [AIN_W-1:0] AIN_VALUE_I,
  input wire logic [AIN_W-1:0] AIN_MIN_I,
  // Reset sources
  input wire logic RESET_KEY_I,
  input wire logic RESET_DIN_I,
  input wire logic RESET_SERIAL_I,
  // Supply and fieldbus state
  input wire logic MAINS_OK_I,
  input wire logic AUX24_OK_I,
  input wire logic BUS_PRESENT_I,
  input wire logic BUS_OK_I,
  input wire logic BUS_LOCAL_I,
  input wire logic BUS_NO_MASTER_I,
  // Log read
  input wire logic [PTR_W-1:0] LOG_IDX_I,
  output logic LOG_VALID_O,
  output logic [TIME_W-1:0] LOG_TIME_O,
  output logic [CODE_W-1:0] LOG_CODE_O,
  output logic [MEAS_W-1:0] LOG_MEAS_O,
  output logic [PTR_W-1:0] LOG_COUNT_O,
  // LEDs
  output logic LED_STATUS_O,
  output logic LED_BUS_O,
  output logic LED_ALARM_O,
  output logic LED_WARNING_O,
  output logic LED_POWER_O,
  // Drive state
  output logic MOTOR_COAST_O,
  output logic READY_O,
  output logic TRIP_LOCKED_O,
  output logic LIVE_ZERO_O
);

  // Picks the allowed severity nearest to the request, never above it
  // unless the code allows no warning; such codes take their highest allowed.
  function automatic sev_e resolve(input sev_e req,
                                   input logic [2:0] cls);
    sev_e r;
    r = SEV_LOCK;
    if (cls[CLS_WARN]) begin
      r = SEV_WARN;
    end else if (cls[CLS_ALARM]) begin
      r = SEV_ALARM;
    end
    if (req != SEV_WARN && cls[CLS_ALARM]) begin
      r = SEV_ALARM;
    end
    if (cls[CLS_LOCK] && (req == SEV_LOCK || !cls[CLS_WARN])) begin
      r = SEV_LOCK;
    end
    return r;
  endfunction

  logic slow_ph;
  logic fast_ph;
  logic lz_now;
  logic lz_rep_r;
  logic lz_evt;
  logic ev_valid;
  logic [CODE_W-1:0] ev_code;
  logic ev_act;
  sev_e ev_sev;
  logic [2:0] ev_cls;
  sev_e eff_sev;
  logic trip_evt;
  logic reset_req;
  logic [NUM_CODES-1:0] cause_r;
  logic [NUM_CODES-1:0] warn_cap;
  logic warn_any;
  logic trip_cause;
  trip_state_e state_r;
  trip_state_e state_nxt;
  logic [CODE_W-1:0] trip_code_r;
  logic mains_cycled_r;
  logic [31:0] tick_r;
  logic [TIME_W-1:0] time_r;
  logic [MEAS_W-1:0] meas_prev_r;
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] count_r;
  logic [PTR_W:0] rsum;
  logic [PTR_W-1:0] raddr;
  logic [ENTRY_W-1:0] rdata;
  logic healthy;

  flash_gen #(
    .HALF_CYCLES(SLOW_HALF_CYCLES)
  ) u_slow (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .phase_o(slow_ph)
  );

  flash_gen #(
    .HALF_CYCLES(FAST_HALF_CYCLES)
  ) u_fast (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .phase_o(fast_ph)
  );

  // Live zero: value*2 below minimum means under half of it
  assign lz_now = LIVE_ZERO_EN_I &&
                  ({AIN_VALUE_I, 1'b0} < {1'b0, AIN_MIN_I});

  // An external event has the slot; a live zero change retries next cycle
  assign lz_evt = (lz_now != lz_rep_r) && !FAULT_VALID_I;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      lz_rep_r <= 1'b0;
    end else if (lz_evt) begin
      lz_rep_r <= lz_now;
    end
  end

  assign ev_valid = FAULT_VALID_I | lz_evt;
  assign ev_code = FAULT_VALID_I ? FAULT_CODE_I : FC_LIVE_ZERO;
  assign ev_act = FAULT_VALID_I ? FAULT_ACTIVE_I : lz_now;
  assign ev_sev = FAULT_VALID_I ? sev_e'(FAULT_SEV_I) : SEV_WARN;

  always_comb begin
    ev_cls = fault_class(ev_code);
    if (ev_code == FC_MOTOR_OVL || ev_code == FC_THERMISTOR) begin
      ev_cls = MOTOR_THERM_ALARM_I ? CLS_A : CLS_W;
    end
  end

  assign eff_sev = resolve(ev_sev, ev_cls);
  assign trip_evt = ev_valid && ev_act && ev_cls != CLS_NONE &&
                    eff_sev != SEV_WARN;
  assign reset_req = RESET_KEY_I | RESET_DIN_I | RESET_SERIAL_I;

  // Per code: cause present, and whether that code may show a warning
  for (genvar i = 0; i < NUM_CODES; i++) begin : g_cause
    assign warn_cap[i] = |(fault_class(CODE_W'(i)) & CLS_W);
    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
        cause_r[i] <= 1'b0;
      end else if (ev_valid && ev_code == CODE_W'(i)) begin
        cause_r[i] <= ev_act && ev_cls != CLS_NONE;
      end
    end
  end

  assign warn_any = |(cause_r & warn_cap);
  assign trip_cause = cause_r[trip_code_r];

  // Trip state: a new trip in the same cycle as a reset wins
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TS_RUN: begin
        if (trip_evt) begin
          state_nxt = (eff_sev == SEV_LOCK) ? TS_LOCK : TS_TRIP;
        end
      end
      TS_TRIP: begin
        if (trip_evt && eff_sev == SEV_LOCK) begin
          state_nxt = TS_LOCK;
        end else if (trip_evt) begin
          state_nxt = TS_TRIP;
        end else if (reset_req) begin
          state_nxt = TS_RUN;
        end else if (AUTO_RESET_EN_I && !trip_cause) begin
          state_nxt = TS_RUN;
        end
      end
      TS_LOCK: begin
        if (!trip_evt && reset_req && mains_cycled_r && MAINS_OK_I) begin
          state_nxt = TS_RUN;
        end
      end
      default: state_nxt = TS_RUN;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_r <= TS_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      trip_code_r <= '0;
    end else if (trip_evt) begin
      trip_code_r <= ev_code;
    end
  end

  // Mains loss is remembered only while locked
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      mains_cycled_r <= 1'b0;
    end else if (state_r != TS_LOCK) begin
      mains_cycled_r <= 1'b0;
    end else if (!MAINS_OK_I) begin
      mains_cycled_r <= 1'b1;
    end
  end

  // Internal clock for time stamps, one count per tick period
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      tick_r <= '0;
      time_r <= TIME_RST;
    end else if (tick_r == 32'(TICK_CYCLES - 1)) begin
      tick_r <= '0;
      time_r <= time_r + TIME_W'(1);
    end else begin
      tick_r <= tick_r + 32'h0000_0001;
    end
  end

  // One cycle old sample so the log shows the value before the failure
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      meas_prev_r <= MEAS_RST;
    end else begin
      meas_prev_r <= MEAS_I;
    end
  end

  // Ring buffer: the pointer wraps and overwrites the oldest entry
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wr_ptr_r <= PTR_RST;
    end else if (trip_evt) begin
      if (wr_ptr_r == PTR_W'(LOG_DEPTH - 1)) begin
        wr_ptr_r <= PTR_RST;
      end else begin
        wr_ptr_r <= wr_ptr_r + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      count_r <= PTR_RST;
    end else if (trip_evt && count_r != PTR_W'(LOG_DEPTH)) begin
      count_r <= count_r + PTR_W'(1);
    end
  end

  // Index 0 is the newest entry
  always_comb begin
    rsum = {1'b0, wr_ptr_r} + (PTR_W + 1)'(LOG_DEPTH - 1) -
           {1'b0, LOG_IDX_I};
    if (LOG_IDX_I >= count_r) begin
      raddr = PTR_RST;
    end else if (rsum >= (PTR_W + 1)'(LOG_DEPTH)) begin
      raddr = PTR_W'(rsum - (PTR_W + 1)'(LOG_DEPTH));
    end else begin
      raddr = PTR_W'(rsum);
    end
  end

  fault_log_mem u_log (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .we_i(trip_evt),
    .waddr_i(wr_ptr_r),
    .wdata_i({time_r, ev_code, meas_prev_r}),
    .raddr_i(raddr),
    .rdata_o(rdata)
  );

  assign LOG_TIME_O = rdata[ENTRY_W-1 -: TIME_W];
  assign LOG_CODE_O = rdata[MEAS_W +: CODE_W];
  assign LOG_MEAS_O = rdata[MEAS_W-1:0];

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      LOG_VALID_O <= 1'b0;
      LOG_COUNT_O <= PTR_RST;
    end else begin
      LOG_VALID_O <= LOG_IDX_I < count_r;
      LOG_COUNT_O <= count_r;
    end
  end

  assign healthy = state_r == TS_RUN && !warn_any;

  // LEDs, all from flip-flops
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      LED_STATUS_O <= 1'b0;
    end else if (healthy) begin
      LED_STATUS_O <= 1'b0;
    end else begin
      case (stat_mode_e'(STATUS_LED_MODE_I))
        ST_OFF: LED_STATUS_O <= 1'b0;
        ST_ON: LED_STATUS_O <= 1'b1;
        ST_SLOW: LED_STATUS_O <= slow_ph;
        ST_FAST: LED_STATUS_O <= fast_ph;
        default: LED_STATUS_O <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      LED_BUS_O <= 1'b0;
    end else if (!BUS_PRESENT_I || !BUS_OK_I) begin
      LED_BUS_O <= 1'b0;
    end else if (BUS_LOCAL_I) begin
      LED_BUS_O <= slow_ph;
    end else if (BUS_NO_MASTER_I) begin
      LED_BUS_O <= fast_ph;
    end else begin
      LED_BUS_O <= 1'b1;
    end
  end

  // Trip lock shares one phase so both LEDs flash together
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      LED_ALARM_O <= 1'b0;
      LED_WARNING_O <= 1'b0;
    end else begin
      LED_ALARM_O <= (state_r != TS_RUN) & slow_ph;
      LED_WARNING_O <= (warn_any | state_r == TS_LOCK) &
                       slow_ph;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      LED_POWER_O <= 1'b0;
    end else begin
      LED_POWER_O <= MAINS_OK_I | AUX24_OK_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      MOTOR_COAST_O <= 1'b0;
      READY_O <= 1'b0;
      TRIP_LOCKED_O <= 1'b0;
      LIVE_ZERO_O <= 1'b0;
    end else begin
      MOTOR_COAST_O <= state_nxt != TS_RUN;
      READY_O <= state_nxt == TS_RUN;
      TRIP_LOCKED_O <= state_nxt == TS_LOCK;
      LIVE_ZERO_O <= lz_now;
    end
  end

endmodule
`default_nettype wire

//--- fault_status_manager_sva.sv
// Concurrent checks on the fault and status manager ports
`timescale 1ns/1ns
`default_nettype none
module fault_status_manager_sva
  import fault_status_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic FAULT_VALID_I,
  input wire logic [CODE_W-1:0] FAULT_CODE_I,
  input wire logic FAULT_ACTIVE_I,
  input wire logic AUTO_RESET_EN_I,
  input wire logic RESET_KEY_I,
  input wire logic RESET_DIN_I,
  input wire logic RESET_SERIAL_I,
  input wire logic MAINS_OK_I,
  input wire logic AUX24_OK_I,
  input wire logic BUS_PRESENT_I,
  input wire logic BUS_OK_I,
  input wire logic BUS_LOCAL_I,
  input wire logic BUS_NO_MASTER_I,
  input wire logic [PTR_W-1:0] LOG_COUNT_O,
  input wire logic LED_BUS_O,
  input wire logic LED_ALARM_O,
  input wire logic LED_POWER_O,
  input wire logic MOTOR_COAST_O,
  input wire logic READY_O,
  input wire logic TRIP_LOCKED_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic any_rst;
  logic ev;
  assign any_rst = RESET_KEY_I | RESET_DIN_I | RESET_SERIAL_I;
  assign ev = FAULT_VALID_I & FAULT_ACTIVE_I;
  // Outputs are registered, so the edge right after reset is skipped
  AST_POWER: assert property (!$past(SYS_RST_I) |->
    LED_POWER_O == $past(MAINS_OK_I | AUX24_OK_I)) else $error("power led");
  AST_BUS_OFF: assert property (!$past(SYS_RST_I) &&
    !$past(BUS_PRESENT_I && BUS_OK_I) |-> !LED_BUS_O) else $error("bus off");
  AST_BUS_ON: assert property (!$past(SYS_RST_I) && $past(BUS_PRESENT_I &&
    BUS_OK_I && !BUS_LOCAL_I && !BUS_NO_MASTER_I) |-> LED_BUS_O)
    else $error("bus on");
  AST_ALARM_OFF: assert property (!$past(MOTOR_COAST_O) |->
    !LED_ALARM_O) else $error("alarm led without trip");
  AST_READY: assert property (!$past(SYS_RST_I) |->
    READY_O == !MOTOR_COAST_O) else $error("ready vs coast");
  AST_LOCK_COAST: assert property (TRIP_LOCKED_O |->
    MOTOR_COAST_O) else $error("lock without coast");
  AST_LOCK_CODES: assert property (ev && FAULT_CODE_I inside
    {7'h0e, 7'h0f, 7'h10, 7'h23, [7'h25:7'h2d]} |=> TRIP_LOCKED_O)
    else $error("lock code did not lock");
  AST_WARN_ONLY: assert property (FAULT_VALID_I && !MOTOR_COAST_O &&
    FAULT_CODE_I inside {7'h05, 7'h06, 7'h21, 7'h63} |=> !MOTOR_COAST_O)
    else $error("warn code tripped");
  AST_TUNE: assert property (ev && !TRIP_LOCKED_O && FAULT_CODE_I inside
    {7'h32, 7'h33, [7'h36:7'h38]} |=> MOTOR_COAST_O && !TRIP_LOCKED_O)
    else $error("tuning code class");
  AST_RESET: assert property (MOTOR_COAST_O && !TRIP_LOCKED_O && any_rst &&
    !FAULT_VALID_I |=> !MOTOR_COAST_O) else $error("reset ignored");
  AST_LATCH: assert property (MOTOR_COAST_O && !any_rst &&
    !AUTO_RESET_EN_I |=> MOTOR_COAST_O) else $error("trip not latched");
  AST_COUNT: assert property (LOG_COUNT_O <= 4'ha)
    else $error("log count above depth");
  COV_LOCK: cover property (TRIP_LOCKED_O ##1 !TRIP_LOCKED_O);
  COV_RESET: cover property (MOTOR_COAST_O && any_rst);
  COV_FULL: cover property (LOG_COUNT_O == 4'ha && ev);
endmodule
bind fault_status_manager fault_status_manager_sva sva (.CLK_I(CLK_I),
  .SYS_RST_I(SYS_RST_I), .FAULT_VALID_I(FAULT_VALID_I),
  .FAULT_CODE_I(FAULT_CODE_I), .FAULT_ACTIVE_I(FAULT_ACTIVE_I),
  .AUTO_RESET_EN_I(AUTO_RESET_EN_I), .RESET_KEY_I(RESET_KEY_I),
  .RESET_DIN_I(RESET_DIN_I), .RESET_SERIAL_I(RESET_SERIAL_I),
  .MAINS_OK_I(MAINS_OK_I), .AUX24_OK_I(AUX24_OK_I),
  .BUS_PRESENT_I(BUS_PRESENT_I), .BUS_OK_I(BUS_OK_I),
  .BUS_LOCAL_I(BUS_LOCAL_I), .BUS_NO_MASTER_I(BUS_NO_MASTER_I),
  .LOG_COUNT_O(LOG_COUNT_O), .LED_BUS_O(LED_BUS_O),
  .LED_ALARM_O(LED_ALARM_O), .LED_POWER_O(LED_POWER_O),
  .MOTOR_COAST_O(MOTOR_COAST_O), .READY_O(READY_O),
  .TRIP_LOCKED_O(TRIP_LOCKED_O));
`default_nettype wire

//--- panel_model.sv
// Operator panel, serial master and supply model driving reset sources
`timescale 1ns/1ns
`default_nettype none
module panel_model (
  input wire logic clk_i,
  output logic key_o,
  output logic din_o,
  output logic ser_o,
  output logic mains_o
);
  initial begin
    {key_o, din_o, ser_o} = 3'h0;
    mains_o = 1'h1;
  end
  // One-cycle request from a single source; 0 key, 1 input, 2 serial
  task automatic press(input int src);
    @(posedge clk_i);
    key_o <= (src == 0);
    din_o <= (src == 1);
    ser_o <= (src == 2);
    @(posedge clk_i);
    {key_o, din_o, ser_o} <= 3'h0;
  endtask
  // A lock is only cleared by a reset after mains returns
  task automatic power_cycle(input int src);
    @(posedge clk_i);
    mains_o <= 1'h0;
    repeat (4) @(posedge clk_i);
    mains_o <= 1'h1;
    repeat (2) @(posedge clk_i);
    press(src);
  endtask
endmodule
`default_nettype wire

//--- tb_fault_status_manager.sv
// Self-checking testbench for the fault and status manager
`timescale 1ns/1ns
`default_nettype none
module tb_fault_status_manager;
  import fault_status_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic valid = 1'h0;
  logic active = 1'h0;
  logic therm = 1'h0;
  logic aen = 1'h0;
  logic lzen = 1'h0;
  logic aux = 1'h0;
  logic [3:0] bus = 4'h0;
  logic [CODE_W-1:0] code = 7'h00;
  logic [1:0] sev = 2'h0;
  logic [1:0] smode = 2'h1;
  logic [MEAS_W-1:0] meas = 16'h0000;
  logic [AIN_W-1:0] ain = 12'h000;
  logic [AIN_W-1:0] amin = 12'h000;
  logic [PTR_W-1:0] idx = 4'h0;
  wire logic key, din, ser, mains, lv, ls, lb, la, lw, lp, coast, ready;
  wire logic locked, lz;
  wire logic [TIME_W-1:0] ltime;
  wire logic [CODE_W-1:0] lcode;
  wire logic [MEAS_W-1:0] lmeas;
  wire logic [PTR_W-1:0] lcnt;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int ha, hw, hs;
  logic [CODE_W-1:0] rc [10];
  logic [MEAS_W-1:0] rm [10];
  logic [CODE_W-1:0] tbl [12] = '{7'h02, 7'h04, 7'h07, 7'h08, 7'h0d, 7'h09,
    7'h0c, 7'h0e, 7'h23, 7'h28, 7'h32, 7'h38};
  logic [TIME_W-1:0] t0;
  logic [1:0] s;
  panel_model panel (.clk_i(clk), .key_o(key), .din_o(din), .ser_o(ser),
    .mains_o(mains));
  fault_status_manager #(.TICK_CYCLES(4), .SLOW_HALF_CYCLES(8),
    .FAST_HALF_CYCLES(3)) dut (.CLK_I(clk), .SYS_RST_I(rst),
    .FAULT_VALID_I(valid), .FAULT_CODE_I(code), .FAULT_ACTIVE_I(active),
    .FAULT_SEV_I(sev), .MEAS_I(meas), .MOTOR_THERM_ALARM_I(therm),
    .AUTO_RESET_EN_I(aen), .STATUS_LED_MODE_I(smode),
    .LIVE_ZERO_EN_I(lzen), .AIN_VALUE_I(ain), .AIN_MIN_I(amin),
    .RESET_KEY_I(key), .RESET_DIN_I(din), .RESET_SERIAL_I(ser),
    .MAINS_OK_I(mains), .AUX24_OK_I(aux), .BUS_PRESENT_I(bus[3]),
    .BUS_OK_I(bus[2]), .BUS_LOCAL_I(bus[1]), .BUS_NO_MASTER_I(bus[0]),
    .LOG_IDX_I(idx), .LOG_VALID_O(lv), .LOG_TIME_O(ltime),
    .LOG_CODE_O(lcode), .LOG_MEAS_O(lmeas), .LOG_COUNT_O(lcnt),
    .LED_STATUS_O(ls), .LED_BUS_O(lb), .LED_ALARM_O(la),
    .LED_WARNING_O(lw), .LED_POWER_O(lp), .MOTOR_COAST_O(coast),
    .READY_O(ready), .TRIP_LOCKED_O(locked), .LIVE_ZERO_O(lz));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic end_sim();
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Generous ceiling: the full sequence needs well under 10000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Measurement is set a cycle ahead because the log keeps the prior sample
  task automatic fire(input logic [6:0] c, input logic [1:0] sv,
    input logic a, input logic [15:0] m);
    @(posedge clk);
    meas <= m;
    @(posedge clk);
    valid <= 1'h1;
    code <= c;
    sev <= sv;
    active <= a;
    @(posedge clk);
    valid <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] i, input logic [6:0] c,
    input logic [15:0] m);
    @(posedge clk);
    idx <= i;
    repeat (2) @(posedge clk);
    #1;
    chk(lv, 1'h1);
    chk(lcode, c);
    chk(lmeas, m);
  endtask
  // High-cycle counts over a window of five flash half periods
  task automatic watch();
    ha = 0;
    hw = 0;
    hs = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      ha += la;
      hw += lw;
      hs += ls;
    end
  endtask
  function automatic logic exp_lock(input logic [6:0] c, input logic [1:0] v);
    if (c inside {7'h0e, 7'h0f, 7'h10, 7'h23, [7'h25:7'h2d]}) begin
      return 1'h1;
    end
    return (c inside {7'h02, 7'h04, 7'h07, 7'h08, 7'h0d}) && v == 2'h2;
  endfunction
  // Lit cycles of the status LED over one watch window while unhealthy
  function automatic logic ls_ok(input logic [1:0] m, input int h);
    if (m == 2'h0) begin
      return h == 0;
    end
    if (m == 2'h1) begin
      return h == 40;
    end
    return h inside {[10:30]};
  endfunction
  initial begin
    void'($urandom(69));
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      bus <= i[3:0];
      aux <= i[0];
      repeat (3) @(posedge clk);
      #1;
      chk(lp, 1'h1);
      if (!(bus[3] && bus[2])) begin
        chk(lb, 1'h0);
      end else if (bus[1:0] == 2'h0) begin
        chk(lb, 1'h1);
      end
    end
    chk(ls, 1'h0);
    fire(7'h05, 2'h1, 1'h1, 16'h1234);
    watch();
    chk(coast, 1'h0);
    chk(ls, 1'h1);
    chk(hw inside {[10:30]}, 1'h1);
    chk(ha, 0);
    fire(7'h05, 2'h1, 1'h0, 16'h1234);
    watch();
    chk(hw, 0);
    fire(7'h0a, 2'h1, 1'h1, 16'h0001);
    chk(coast, 1'h0);
    fire(7'h0a, 2'h1, 1'h0, 16'h0001);
    @(posedge clk) therm <= 1'h1;
    fire(7'h0b, 2'h1, 1'h1, 16'hbeef);
    chk(coast, 1'h1);
    rd(4'h0, 7'h0b, 16'hbeef);
    fire(7'h0b, 2'h1, 1'h0, 16'h0000);
    panel.press(0);
    for (int k = 0; k < 3; k++) begin
      // Status LED mode drawn at random for each of the three tripped passes
      @(posedge clk) smode <= 2'($urandom);
      fire(7'h0d, 2'h1, 1'h1, 16'h0100 + k[15:0]);
      watch();
      chk(coast, 1'h1);
      chk(ready, 1'h0);
      chk(ha > 5 && hw > 5, 1'h1);
      chk(ls_ok(smode, hs), 1'h1);
      rd(4'h0, 7'h0d, 16'h0100 + k[15:0]);
      fire(7'h0d, 2'h1, 1'h0, 16'h0000);
      watch();
      chk(ha > 5 && hw == 0, 1'h1);
      panel.press(k);
      repeat (2) @(posedge clk);
      #1;
      chk(ready, 1'h1);
    end
    fire(7'h0e, 2'h0, 1'h1, 16'h0042);
    fire(7'h0e, 2'h0, 1'h0, 16'h0042);
    watch();
    chk(ha > 5 && hw > 5, 1'h1);
    panel.press(0);
    repeat (2) @(posedge clk);
    #1;
    chk(locked, 1'h1);
    panel.power_cycle(1);
    repeat (2) @(posedge clk);
    #1;
    chk(locked | coast, 1'h0);
    @(posedge clk) aen <= 1'h1;
    fire(7'h09, 2'h1, 1'h1, 16'h0009);
    chk(coast, 1'h1);
    fire(7'h09, 2'h1, 1'h0, 16'h0009);
    chk(coast, 1'h0);
    @(posedge clk) aen <= 1'h0;
    t0 = 32'h0000_0000;
    for (int k = 0; k < 10; k++) begin
      rc[k] = tbl[$urandom % 12];
      rm[k] = 16'($urandom);
      s = 2'h1 + 2'($urandom % 2);
      fire(rc[k], s, 1'h1, rm[k]);
      chk(coast, 1'h1);
      chk(locked, exp_lock(rc[k], s));
      rd(4'h0, rc[k], rm[k]);
      chk(ltime >= t0, 1'h1);
      t0 = ltime;
      fire(rc[k], s, 1'h0, 16'h0000);
      if (locked === 1'h1) begin
        panel.power_cycle(k % 3);
      end else begin
        panel.press(k % 3);
      end
      repeat (2) @(posedge clk);
      #1;
      chk(coast, 1'h0);
    end
    chk(lcnt, 4'ha);
    rd(4'h9, rc[0], rm[0]);
    rd(4'h0, rc[9], rm[9]);
    @(posedge clk) idx <= 4'ha;
    repeat (2) @(posedge clk);
    #1;
    chk(lv, 1'h0);
    @(posedge clk);
    lzen <= 1'h1;
    amin <= 12'h100;
    ain <= 12'h07f;
    repeat (3) @(posedge clk);
    #1;
    chk(lz, 1'h1);
    @(posedge clk) ain <= 12'h080;
    repeat (3) @(posedge clk);
    #1;
    chk(lz, 1'h0);
    end_sim();
  end
endmodule
`default_nettype wire
